/* hw/dhb_bridge.sv */
// dcr to mac host bus bridge with four directly addressed registers
`timescale 1ns/10ps
module dhb_bridge
    import dhb_pkg::*;
#(
    parameter logic [DCR_AW-IDX_W-1:0] BRIDGE_BASE_ATTRIBUTE = 8'h00
) (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic              bus_select_strap_i,
    input  wire logic              dcr_read_i,
    input  wire logic              dcr_write_i,
    input  wire logic [DCR_AW-1:0] dcr_abus_i,
    input  wire logic [31:0]       dcr_dbus_i,
    input  wire logic [31:0]       host_rd_data_i,
    input  wire logic              host_miim_rdy_i,
    output logic [31:0]            dcr_dbus_o,
    output logic                   dcr_ack_o,
    output dhb_host_req_s          host_o,
    output logic                   host_done_irq_o
);
    // big-endian register images
    logic [31:0]  upper_data_word_r;
    logic [31:0]  lower_data_word_r;
    logic [31:0]  bridge_command_reg_r;
    logic [6:0]   done_event_flags_r;
    logic [6:0]   done_event_mask_r;
    logic [15:0]  mgmt_write_hold_r;
    logic [6:0]   busy_kind_r;
    logic         busy_r;
    logic         strap_r;

    // sample the strap every cycle after reset release; sel_hit follows it one cycle late
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_r <= 1'b0;
        end else begin
            strap_r <= bus_select_strap_i;
        end
    end

    // address decode
    wire          sel_hit = strap_r &&
        (dcr_abus_i[DCR_AW-1:IDX_W] == BRIDGE_BASE_ATTRIBUTE);
    wire [1:0]    reg_idx = dcr_abus_i[IDX_W-1:0];
    wire [31:0]   lower_le   = dhb_swap(lower_data_word_r);
    wire [31:0]   cmd_reg_le = dhb_swap(bridge_command_reg_r);
    wire          wr_hit  = sel_hit && dcr_write_i && !dcr_ack_o;
    wire          rd_hit  = sel_hit && dcr_read_i && !dcr_ack_o;
    wire          cmd_wr  = wr_hit && (reg_idx == REG_CMD);

    // command decode on the incoming word (little-endian view)
    wire [31:0]   cmd_le   = dhb_swap(dcr_dbus_i);
    wire          cmd_we   = cmd_le[CMD_WE_BIT];
    wire [9:0]    cmd_code = cmd_le[CMD_CODE_W-1:0];
    wire          is_fab   = (cmd_code <= FAB_A_HI) ||
        (cmd_code >= FAB_B_LO && cmd_code <= FAB_B_HI);
    wire          is_mac   = cmd_code >= MAC_LO && cmd_code <= MAC_HI;
    wire          is_irst  = cmd_code == CODE_IRST;
    wire          is_iren  = cmd_code == CODE_IREN;
    wire          is_mwh   = cmd_code == CODE_MWH;
    wire          is_mdio  = cmd_code == CODE_MDIO;
    wire          is_af    = cmd_code >= 10'h380 && is_mac;
    // fabric registers are read only; a write there is a stray command
    wire          host_go  = cmd_wr && !busy_r &&
        ((is_fab && !cmd_we) || is_mac || is_mdio);
    wire          local_go = cmd_wr && !busy_r &&
        (is_irst || is_iren || is_mwh);
    wire          two_word = !cmd_we &&
        (is_fab || cmd_code == GAT_W1);

    // one-hot kind of access, used for ready and done event bits
    wire [6:0]    go_kind =
        is_mdio ? (cmd_we ? 7'h04 : 7'h02) :
        is_fab  ? 7'h01 :
        is_af   ? (cmd_we ? 7'h10 : 7'h08) :
                  (cmd_we ? 7'h40 : 7'h20);
    wire [6:0]    rdy_bits = RDY_IDLE & ~busy_kind_r;
    wire          rdy_sum  = &rdy_bits;
    wire [31:0]   rdy_le   = {15'h0000, rdy_sum, 9'h000, rdy_bits};

    wire          seq_done;
    wire [31:0]   seq_w0;
    wire [31:0]   seq_w1;
    wire [31:0]   host_wdata = is_mdio ?
        {16'h0000, mgmt_write_hold_r} :
        dhb_swap(lower_data_word_r);
    wire dhb_host_kind_e seq_kind = is_mdio ? HK_MDIO :
        (is_fab ? HK_FAB : HK_CFG);

    dhb_host_seq u_seq (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .start_i    (host_go),
        .kind_i     (seq_kind),
        .write_i    (cmd_we),
        .two_word_i (two_word),
        .addr_i     (cmd_code),
        .wr_data_i  (host_wdata),
        .rd_data_i  (host_rd_data_i),
        .miim_rdy_i (host_miim_rdy_i),
        .host_o     (host_o),
        .done_o     (seq_done),
        .word0_o    (seq_w0),
        .word1_o    (seq_w1)
    );

    // read mux, answered on the ack cycle
    wire [31:0]   rd_mux =
        (reg_idx == REG_UPPER) ? upper_data_word_r :
        (reg_idx == REG_LOWER) ? lower_data_word_r :
        (reg_idx == REG_CMD)   ? bridge_command_reg_r :
                                 dhb_swap(rdy_le);

    // dcr slave handshake: ack one cycle after a hit, dropped next cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dcr_ack_o  <= 1'b0;
            dcr_dbus_o <= WORD_ZERO;
        end else begin
            dcr_ack_o  <= wr_hit || rd_hit;
            dcr_dbus_o <= rd_hit ? rd_mux : dcr_dbus_i;
        end
    end

    // command register and busy tracking
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bridge_command_reg_r <= WORD_ZERO;
            busy_r               <= 1'b0;
            busy_kind_r          <= EVT_RESET;
        end else begin
            if (cmd_wr && !busy_r) begin
                bridge_command_reg_r <= dhb_swap(cmd_le & CMD_MASK);
            end
            if (host_go) begin
                busy_r      <= 1'b1;
                busy_kind_r <= go_kind;
            end else if (seq_done) begin
                busy_r      <= 1'b0;
                busy_kind_r <= EVT_RESET;
            end
        end
    end

    // data words: dcr writes, indirect reads and local targets
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            upper_data_word_r <= WORD_ZERO;
            lower_data_word_r <= WORD_ZERO;
            mgmt_write_hold_r <= MWH_RESET;
            done_event_mask_r <= EVT_RESET;
        end else begin
            if (wr_hit && reg_idx == REG_UPPER && !busy_r) begin
                upper_data_word_r <= dcr_dbus_i;
            end
            if (wr_hit && reg_idx == REG_LOWER && !busy_r) begin
                lower_data_word_r <= dcr_dbus_i;
            end
            if (seq_done && !cmd_reg_le[CMD_WE_BIT]) begin
                lower_data_word_r <= dhb_swap(seq_w0);
                if (busy_kind_r[RDY_FAB_RD] ||
                    cmd_reg_le[CMD_CODE_W-1:0] == GAT_W1) begin
                    upper_data_word_r <= dhb_swap(seq_w1);
                end
            end
            if (local_go) begin
                if (is_irst && !cmd_we) begin
                    lower_data_word_r <=
                        dhb_swap({25'h0000000, done_event_flags_r});
                end else if (is_iren && cmd_we) begin
                    done_event_mask_r <= lower_le[KIND_W-1:0];
                end else if (is_iren) begin
                    lower_data_word_r <=
                        dhb_swap({25'h0000000, done_event_mask_r});
                end else if (is_mwh && cmd_we) begin
                    mgmt_write_hold_r <= lower_le[15:0];
                end else if (is_mwh) begin
                    lower_data_word_r <=
                        dhb_swap({16'h0000, mgmt_write_hold_r});
                end
            end
        end
    end

    // done events: a new completion wins over a clearing write
    wire          irst_wr = local_go && is_irst && cmd_we;
    wire [6:0]    clr_bits = irst_wr ? lower_le[KIND_W-1:0] : EVT_RESET;
    wire [6:0]    set_bits = seq_done ?
        (busy_kind_r & done_event_mask_r) : EVT_RESET;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_event_flags_r <= EVT_RESET;
            host_done_irq_o    <= 1'b0;
        end else begin
            done_event_flags_r <= (done_event_flags_r & ~clr_bits) | set_bits;
            host_done_irq_o    <= |((done_event_flags_r & ~clr_bits) |
                                    set_bits);
        end
    end

    // checks
    a_busy_refuses: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        busy_r && cmd_wr |=> $stable(bridge_command_reg_r))
        else $error("command taken while busy");
    a_ready_summary: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        busy_r |-> !rdy_sum)
        else $error("summary ready high while busy");
    a_go_clears_rdy: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        host_go |=> busy_kind_r != EVT_RESET)
        else $error("ready bit not cleared on start");
    a_ack_follows: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (wr_hit || rd_hit) |=> dcr_ack_o ##1 !dcr_ack_o)
        else $error("dcr ack not one cycle");
    a_mac_addr_code: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        host_go && is_mac |=> ##1 host_o.addr == $past(cmd_code, 2))
        else $error("host address differs from code");
    a_stray_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        cmd_wr && !busy_r && !(is_fab || is_mac || is_mdio || is_irst ||
        is_iren || is_mwh) |=> !busy_r && $stable(lower_data_word_r))
        else $error("stray code had an effect");
    a_cfg_done_time: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        host_go && !is_mdio |-> ##[2:3] seq_done)
        else $error("config access did not finish in time");
    a_mdio_select: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        host_go && is_mdio |=> host_o.miim_sel ##1 host_o.req)
        else $error("mdio access not launched");
    a_fab_no_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        cmd_wr && is_fab && cmd_we && !busy_r |=> !busy_r)
        else $error("fabric write started a host access");
    a_cfg_write_op: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        host_go && cmd_we && !is_mdio |=> host_o.opcode == 2'h1)
        else $error("config write not flagged on host");
endmodule

/* inc/dhb_pkg.sv */
// shared constants and carriers for the dcr host bridge
package dhb_pkg;
    // direct register index (low dcr address bits)
    localparam logic [1:0] REG_UPPER = 2'h0;
    localparam logic [1:0] REG_LOWER = 2'h1;
    localparam logic [1:0] REG_CMD   = 2'h2;
    localparam logic [1:0] REG_RDY   = 2'h3;
    localparam int         DCR_AW    = 10;
    localparam int         IDX_W     = 2;
    // command register fields, little-endian position (big-endian 31-n)
    localparam int         CMD_WE_BIT = 15;   // big-endian bit 16
    localparam int         CMD_CODE_W = 10;   // big-endian bits 22:31
    localparam logic [31:0] CMD_MASK  = 32'h0000_83FF;
    // address code ranges and singles
    localparam logic [9:0] FAB_A_LO  = 10'h000;
    localparam logic [9:0] FAB_A_HI  = 10'h02F;
    localparam logic [9:0] FAB_B_LO  = 10'h040;
    localparam logic [9:0] FAB_B_HI  = 10'h04F;
    localparam logic [9:0] MAC_LO    = 10'h200;
    localparam logic [9:0] MAC_HI    = 10'h390;
    localparam logic [9:0] CODE_IRST = 10'h3A0;
    localparam logic [9:0] CODE_IREN = 10'h3A4;
    localparam logic [9:0] CODE_MWH  = 10'h3B0;
    localparam logic [9:0] CODE_MDIO = 10'h3B4;
    // general address table word 1 host address (read gives two words)
    localparam logic [9:0] GAT_W1    = 10'h38C;
    // ready / event bit positions (little-endian; big-endian 25..31)
    localparam int RDY_CFG_WR = 6;
    localparam int RDY_CFG_RD = 5;
    localparam int RDY_AF_WR  = 4;
    localparam int RDY_AF_RD  = 3;
    localparam int RDY_MD_WR  = 2;
    localparam int RDY_MD_RD  = 1;
    localparam int RDY_FAB_RD = 0;
    localparam int RDY_SUM    = 16;   // big-endian bit 15
    localparam int KIND_W     = 7;
    localparam logic [6:0]  RDY_IDLE  = 7'h7F;
    localparam logic [6:0]  EVT_RESET = 7'h00;
    localparam logic [15:0] MWH_RESET = 16'h0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // host bus request toward the mac configuration logic
    typedef struct packed {
        logic        req;
        logic        miim_sel;
        logic [1:0]  opcode;
        logic [9:0]  addr;
        logic [31:0] wr_data;
    } dhb_host_req_s;
    typedef enum logic [1:0] {
        HK_CFG,
        HK_FAB,
        HK_MDIO
    } dhb_host_kind_e;
    // big-endian bit n is vector bit 31-n, which is host bit 31-n: a straight
    // wire, kept in one function so every crossing point stays marked
    function automatic logic [31:0] dhb_swap(input logic [31:0] v);
        logic [31:0] r;
        r = WORD_ZERO;
        for (int i = 0; i < 32; i++) begin
            r[i] = v[i];
        end
        return r;
    endfunction
endpackage

/* hw/dhb_host_seq.sv */
// host bus sequencer: drives one host access and reports completion
`timescale 1ns/10ps
module dhb_host_seq
    import dhb_pkg::*;
(
    input  wire logic          clock_i,
    input  wire logic          rst_n_i,
    input  wire logic          start_i,
    input  wire dhb_host_kind_e kind_i,
    input  wire logic          write_i,
    input  wire logic          two_word_i,
    input  wire logic [9:0]    addr_i,
    input  wire logic [31:0]   wr_data_i,
    input  wire logic [31:0]   rd_data_i,
    input  wire logic          miim_rdy_i,
    output dhb_host_req_s      host_o,
    output logic               done_o,
    output logic [31:0]        word0_o,
    output logic [31:0]        word1_o
);
    typedef enum {S_IDLE, S_W0, S_W1, S_MREQ, S_MWAIT} dhb_seq_e;
    dhb_seq_e      state_r;
    logic          two_r;
    logic          wr_r;
    logic          miim_q_r;
    logic          miim_s_r;
    logic [1:0]    hold_r;
    // cycles for the ready drop to cross the mac and both sync flops
    localparam logic [1:0] RDY_SETTLE = 2'h3;

    // mdio ready comes from the mac clock side: two flops first
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            miim_q_r <= 1'b1;
            miim_s_r <= 1'b1;
        end else begin
            miim_q_r <= miim_rdy_i;
            miim_s_r <= miim_q_r;
        end
    end

    // config reads return data the edge after the address; hold low 2 cycles
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= S_IDLE;
            host_o  <= '0;
            done_o  <= 1'b0;
            word0_o <= WORD_ZERO;
            word1_o <= WORD_ZERO;
            two_r   <= 1'b0;
            wr_r    <= 1'b0;
            hold_r  <= 2'h0;
        end else begin
            done_o      <= 1'b0;
            host_o.req  <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (start_i) begin
                        two_r          <= two_word_i;
                        wr_r           <= write_i;
                        host_o.addr    <= addr_i;
                        host_o.wr_data <= wr_data_i;
                        host_o.miim_sel <= (kind_i == HK_MDIO);
                        host_o.opcode  <= write_i ? 2'h1 : 2'h2;
                        state_r <= (kind_i == HK_MDIO) ? S_MREQ : S_W0;
                    end
                end
                S_W0: begin
                    host_o.opcode <= 2'h2;  // drop write enable after 1 cycle
                    word0_o <= rd_data_i;
                    state_r <= S_W1;
                    if (wr_r) begin
                        host_o.miim_sel <= 1'b1;  // park between accesses
                        done_o  <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                S_W1: begin
                    if (two_r) begin
                        word1_o <= rd_data_i;
                    end
                    // select low for exactly two cycles on a read
                    host_o.miim_sel <= 1'b1;
                    done_o  <= 1'b1;
                    state_r <= S_IDLE;
                end
                S_MREQ: begin
                    host_o.req <= 1'b1;
                    hold_r     <= RDY_SETTLE;
                    state_r    <= S_MWAIT;
                end
                S_MWAIT: begin
                    // stale synced ready would end the frame at once
                    if (hold_r != 2'h0) begin
                        hold_r <= hold_r - 2'h1;
                    end else if (miim_s_r) begin
                        word0_o <= {16'h0000, rd_data_i[15:0]};
                        done_o  <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule

/* verification/dhb_mac_model.sv */
// mac host side model: register words, two-word reads, mdio frames
`timescale 1ns/10ps
module dhb_mac_model
    import dhb_pkg::*;
#(
    parameter logic [15:0] MDIO_WORD = 16'h9E61
) (
    input  wire logic          clock_i,
    input  wire logic          rst_n_i,
    input  wire dhb_host_req_s host_i,
    output logic [31:0]        rd_data_o,
    output logic               miim_rdy_o
);
    logic [12:0] prev_r;
    logic        phase_r;
    logic [7:0]  cnt_r;
    logic [31:0] rd_q_r;
    logic        ph_w;
    logic        rd_w;

    // word phase restarts whenever the access changes
    assign ph_w = ({host_i.miim_sel, host_i.opcode, host_i.addr} == prev_r)
                  ? ~phase_r : 1'b0;
    assign rd_w = !host_i.miim_sel && host_i.opcode == 2'h2;
    // config words stand in the same cycle the bridge samples them
    assign rd_data_o = rd_w ?
        {ph_w ? 16'hC3A5 : 16'h5A3C, 6'h00, host_i.addr} : rd_q_r;

    // a released bus inverts each cycle; mdio reads are slow, writes quick
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_r     <= 13'h0000;
            phase_r    <= 1'b0;
            cnt_r      <= 8'h00;
            rd_q_r     <= 32'h0000_0000;
            miim_rdy_o <= 1'b1;
        end else begin
            prev_r    <= {host_i.miim_sel, host_i.opcode, host_i.addr};
            phase_r   <= ph_w;
            rd_q_r    <= ~rd_q_r;
            if (!miim_rdy_o) begin
                cnt_r      <= cnt_r - 8'h01;
                miim_rdy_o <= (cnt_r == 8'h00);
                if (cnt_r == 8'h00) begin
                    rd_q_r <= {16'h0000, MDIO_WORD};
                end
            end else if (host_i.req && host_i.miim_sel) begin
                miim_rdy_o <= 1'b0;  // bus locked until frame ends
                cnt_r      <= (host_i.opcode == 2'h2) ? 8'h28 : 8'h03;
            end else if (host_i.miim_sel) begin
                rd_q_r <= rd_q_r;  // mdio result held
            end
        end
    end
endmodule

/* verification/testbench.sv */
// self-checking bench: bridge registers, host traffic, events, mdio
`timescale 1ns/10ps
module testbench
    import dhb_pkg::*;
;
    localparam logic [7:0]  BASE = 8'hA5;
    localparam logic [15:0] MDIO_WORD = 16'h9E61;
    logic          clock_i;
    logic          rst_n_i;
    logic          dcr_read_i;
    logic          dcr_write_i;
    logic [9:0]    dcr_abus_i;
    logic [31:0]   dcr_dbus_i;
    logic [31:0]   dcr_dbus_o;
    logic          dcr_ack_o;
    logic [31:0]   host_rd;
    logic          miim_rdy;
    dhb_host_req_s host_o;
    logic          irq;
    logic [31:0]   rd;
    logic [31:0]   wd;
    logic [31:0]   up;
    logic [9:0]    code;
    logic [9:0]    fab [5];
    integer        seed;
    int            num_errors;
    int            n_tests;

    dhb_bridge #(.BRIDGE_BASE_ATTRIBUTE(BASE)) i_dhb_bridge (
        .clock_i            (clock_i),
        .rst_n_i            (rst_n_i),
        .bus_select_strap_i (1'b1),
        .dcr_read_i         (dcr_read_i),
        .dcr_write_i        (dcr_write_i),
        .dcr_abus_i         (dcr_abus_i),
        .dcr_dbus_i         (dcr_dbus_i),
        .host_rd_data_i     (host_rd),
        .host_miim_rdy_i    (miim_rdy),
        .dcr_dbus_o         (dcr_dbus_o),
        .dcr_ack_o          (dcr_ack_o),
        .host_o             (host_o),
        .host_done_irq_o    (irq)
    );
    dhb_mac_model #(.MDIO_WORD(MDIO_WORD)) i_dhb_mac_model (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .host_i     (host_o),
        .rd_data_o  (host_rd),
        .miim_rdy_o (miim_rdy)
    );

    // one clock: host side ratio of one, phase aligned by construction
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // bit n sits at 31-n on dcr and host alike, so the words match
    function automatic logic [31:0] exp_word(input logic [9:0] a,
                                             input logic ph);
        return {ph ? 16'hC3A5 : 16'h5A3C, 6'h00, a};
    endfunction

    // one dcr access; request held until the ack edge has passed
    task automatic dcr(input logic wr, input logic [1:0] idx,
                       input logic [31:0] d, input logic [7:0] base);
        int k;
        @(posedge clock_i);
        dcr_write_i <= wr;
        dcr_read_i  <= ~wr;
        dcr_abus_i  <= {base, idx};
        dcr_dbus_i  <= d;
        for (k = 0; k < 20 && dcr_ack_o !== 1'b1; k++) begin
            @(posedge clock_i);
            #1;
        end
        rd = dcr_dbus_o;
        check(32'(k < 20), 32'(base == BASE));
        if (k == 20 && base == BASE) tally_and_finish();
        @(posedge clock_i);
        dcr_write_i <= 1'b0;
        dcr_read_i  <= 1'b0;
    endtask

    task automatic rchk(input logic [1:0] idx, input logic [31:0] exp);
        dcr(1'b0, idx, 32'h0000_0000, BASE);
        check(rd, exp);
    endtask

    // command write, polled until idle when w is set
    task automatic cmd(input logic we, input logic [9:0] c, input logic w);
        int k;
        dcr(1'b1, REG_CMD, {16'h0000, we, 5'h00, c}, BASE);
        for (k = 0; w && k < 50; k++) begin
            dcr(1'b0, REG_RDY, 32'h0000_0000, BASE);
            if (rd[RDY_SUM] === 1'b1) break;
        end
        if (k == 50) begin
            num_errors++;
            $display("ERROR %0t: bridge stays busy", $time);
            tally_and_finish();
        end
    endtask

    initial begin
        seed = 29030;
        num_errors = 0;
        n_tests = 0;
        fab = '{FAB_A_LO, FAB_A_HI, FAB_B_LO, FAB_B_HI, 10'h020};
        rst_n_i = 1'b0;
        dcr_read_i = 1'b0;
        dcr_write_i = 1'b0;
        dcr_abus_i = 10'h000;
        dcr_dbus_i = 32'h0000_0000;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        // idle state, foreign base ignored, read-only ready word
        rchk(REG_RDY, 32'h0001_007F);
        rchk(REG_CMD, 32'h0000_0000);
        check(32'(irq), 32'h0000_0000);
        dcr(1'b1, REG_LOWER, 32'hFFFF_FFFF, BASE ^ 8'h01);
        dcr(1'b1, REG_RDY, 32'h0000_0000, BASE);
        rchk(REG_RDY, 32'h0001_007F);
        for (int i = 0; i < 4; i++) begin
            wd = $random(seed);
            dcr(1'b1, 2'(i & 1), wd, BASE);
            rchk(2'(i & 1), wd);
        end
        // stray code: no host access, lower data word untouched
        cmd(1'b1, 10'h100, 1'b1);
        rchk(REG_LOWER, wd);
        rchk(REG_CMD, 32'h0000_8100);
        check(32'(host_o.opcode), 32'h0000_0000);
        // config and filter writes then reads, range ends included
        for (int i = 0; i < 8; i++) begin
            code = (i == 0) ? MAC_LO : (i == 1) ? MAC_HI : (i == 2) ? GAT_W1
                 : MAC_LO + 10'(($random(seed) & 32'hFFFF) % 401);
            wd = $random(seed);
            up = $random(seed);
            dcr(1'b1, REG_LOWER, wd, BASE);
            dcr(1'b1, REG_UPPER, up, BASE);
            cmd(1'b1, code, 1'b1);
            check(32'(host_o.addr), 32'(code));
            // select parked high, write enable already dropped
            check(32'({host_o.miim_sel, host_o.opcode}), 32'h6);
            check(host_o.wr_data, wd);
            cmd(1'b0, code, 1'b1);
            rchk(REG_LOWER, exp_word(code, 1'b0));
            rchk(REG_UPPER, code == GAT_W1 ? exp_word(code, 1'b1) : up);
        end
        // fabric reads fill both words; a fabric write does nothing
        for (int i = 0; i < 5; i++) begin
            cmd(1'b0, fab[i], 1'b1);
            rchk(REG_LOWER, exp_word(fab[i], 1'b0));
            rchk(REG_UPPER, exp_word(fab[i], 1'b1));
        end
        cmd(1'b1, 10'h010, 1'b1);
        rchk(REG_LOWER, exp_word(10'h020, 1'b0));
        // completion events: enable, clear, set by a write, clear again
        dcr(1'b1, REG_LOWER, 32'h0000_007F, BASE);
        cmd(1'b1, CODE_IREN, 1'b1);
        dcr(1'b1, REG_LOWER, 32'hFFFF_FFFF, BASE);
        cmd(1'b1, CODE_IRST, 1'b1);
        cmd(1'b0, CODE_IREN, 1'b1);
        rchk(REG_LOWER, 32'h0000_007F);
        cmd(1'b1, MAC_LO, 1'b1);
        cmd(1'b0, CODE_IRST, 1'b1);
        rchk(REG_LOWER, 32'h0000_0040);
        check(32'(irq), 32'h0000_0001);
        dcr(1'b1, REG_LOWER, 32'hFFFF_FFFF, BASE);
        cmd(1'b1, CODE_IRST, 1'b1);
        check(32'(irq), 32'h0000_0000);
        // mdio write from holding word, then slow read hit while busy
        wd = 32'($random(seed) & 32'hFFFF);
        dcr(1'b1, REG_LOWER, wd, BASE);
        cmd(1'b1, CODE_MWH, 1'b1);
        dcr(1'b1, REG_LOWER, ~wd, BASE);
        cmd(1'b1, CODE_MDIO, 1'b1);
        check({16'h0000, host_o.wr_data[15:0]}, wd);
        check(32'({host_o.miim_sel, host_o.opcode}), 32'h5);
        cmd(1'b0, CODE_MDIO, 1'b0);
        rchk(REG_RDY, 32'h0000_007D);
        dcr(1'b1, REG_LOWER, 32'hDEAD_0000, BASE);
        cmd(1'b1, MAC_HI, 1'b1);
        rchk(REG_LOWER, {16'h0000, MDIO_WORD});
        check(32'(host_o.miim_sel), 32'h0000_0001);
        tally_and_finish();
    end
endmodule
